//--- src/cnp_pkg.sv
// cnp_pkg: shared constants for the node parameter set and its master
// assumes: one clock domain, 32-bit apb on the master end
package cnp_pkg;
   // parameter select codes carried on the link
   typedef enum logic [3:0] {
      CNP_P_NODE_ID, CNP_P_BAUD, CNP_P_SYNC_EN, CNP_P_CYCLE, CNP_P_HEARTBEAT,
      CNP_P_AUTOSTART, CNP_P_SRDO_USE, CNP_P_RX_EN, CNP_P_RX_COBID,
      CNP_P_RX_TTYPE, CNP_P_RX_INHIBIT, CNP_P_RX_EVTIMER, CNP_P_SAFETY_UP,
      CNP_P_SRC_SEL
   } cnp_param_e;
   localparam logic [6:0] CNP_NODE_MIN = 7'h01;
   localparam logic [6:0] CNP_NODE_MAX = 7'h7F;
   localparam logic [6:0] CNP_NODE_RST = 7'h01;
   localparam logic [2:0] CNP_BAUD_RST = 3'h0;
   localparam logic [15:0] CNP_HB_MAX = 16'hFF4B; // 65355 ms
   localparam logic [10:0] CNP_RX_COB_MIN = 11'h201;
   localparam logic [10:0] CNP_RX_COB_MAX = 11'h27F;
   localparam logic [10:0] CNP_RX_COB_BASE = 11'h200;
   localparam logic [10:0] CNP_TX_COB_BASE = 11'h180;
   localparam logic [10:0] CNP_TSRDO_BASE = 11'h0FF;
   localparam logic [7:0] CNP_TT_SYNC_MAX = 8'hF0;
   localparam logic [7:0] CNP_TT_EVENT = 8'hFF;
   localparam logic [7:0] CNP_TT_RST = 8'hFF;
   // apb register offsets of the master
   localparam logic [7:0] CNP_A_CMD = 8'h00;   // [3:0] select, [8] go
   localparam logic [7:0] CNP_A_WDATA = 8'h04;
   localparam logic [7:0] CNP_A_STATUS = 8'h08; // busy, ack, rej, evt, op
   localparam logic [7:0] CNP_A_INPUTS = 8'h0C; // case inputs
   localparam logic [7:0] CNP_A_TXCOB = 8'h10;  // tpdo1 cob-id readback
   // microseconds per clock at 10 MHz is 0.1: ten clocks per microsecond
   localparam int CNP_CLK_MHZ = 10;
   localparam int CNP_CLK_PER_US = CNP_CLK_MHZ;
   localparam int CNP_CLK_PER_MS = CNP_CLK_MHZ * 1000;
endpackage

//--- src/cnp_if.sv
// cnp_if: parameter write link between master and node
// assumes: both ends on core_clk; one request held until ack or rej
interface cnp_if;
   logic req;
   logic [3:0] sel;
   logic [31:0] wdata;
   logic ack;
   logic rej;
   logic sync_msg;
   logic tx_pdo;
   logic rx_event;
   logic operational;
   logic [7:0] case_in;
   logic [10:0] tx_cob;
   modport node (input req, sel, wdata, sync_msg, case_in,
      output ack, rej, tx_pdo, rx_event, operational, tx_cob);
   modport master (output req, sel, wdata, sync_msg, case_in,
      input ack, rej, tx_pdo, rx_event, operational, tx_cob);
endinterface

//--- src/cnp_node.sv
// cnp_node: communication parameter set of the scanner node
// assumes: master holds req until ack or rej; one clock core_clk
// What this block does
// R01: node id range 1 to 127
// R02: ids above 63 unused with distance pdos; not enforced, ids up to 127 accepted
// R03: node id change recomputes all cob-ids
// R04: bit rate setting matches bus rate
// R05: sync triggers tpdo within cycle period
// R06: cycle period 0 to 4294967295 us
// R07: heartbeat period 0 to 65355 ms
// R08: autostart enters operational after safety start
// R09: no autostart while srdos in use
// R10: rpdo cob-id only 0x201 to 0x27F
// R11: ttype 0-240 sync, 255 event
// R12: rpdo inhibit time 0 to 65535
// R13: event timer expiry raises receive event
// R14: rpdo fields changeable only while enabled; rx_cob still follows a node id write while disabled
// R15: writable locally or over network
// R16: case inputs from rpdo or srdo
// R17: out of range writes rejected, kept
module cnp_node
   import cnp_pkg::*;
#(
   parameter int CYC_W = 32
) (
   input wire logic core_clk,
   input wire logic rst_n,
   cnp_if.node lnk,
   input wire logic local_req,
   input wire logic [3:0] local_sel,
   input wire logic [31:0] local_wdata,
   output logic local_done,
   output logic [7:0] case_sel,
   output logic [2:0] baud_sel,
   output logic heartbeat
);
   import cnp_pkg::*;
   // counters are built for a 32-bit cycle period only
   if (CYC_W != 32) begin : g_cyc_chk
      $error("cycle period must be 32 bits");
   end
   typedef struct packed {
      logic [6:0] node_id;
      logic [2:0] baud;
      logic sync_en;
      logic [31:0] cycle;
      logic [15:0] hb;
      logic autostart;
      logic srdo_use;
      logic safety_up;
      logic src_srdo;
      logic rx_en;
      logic [10:0] rx_cob;
      logic [7:0] ttype;
      logic [15:0] inhibit;
      logic [15:0] evtimer;
      logic [10:0] tx_cob;
      logic operational;
      logic [31:0] cyc_cnt;
      logic tx_pend;
      logic tx_pdo;
      logic [31:0] hb_cnt;
      logic hb_pulse;
      logic [31:0] ev_cnt;
      logic rx_event;
      logic ack;
      logic rej;
      logic ldone;
      logic [7:0] case_q;
   } cnp_node_s;
   cnp_node_s st_q, st_d;
   logic wr;
   logic [3:0] sel;
   logic [31:0] wd;
   logic ok;
   // local tool has priority; network request waits while local_req is high
   always_comb begin
      wr = 1'b0;
      sel = lnk.sel;
      wd = lnk.wdata;
      if (local_req && !st_q.ldone) begin
         wr = 1'b1; // [R15]
         sel = local_sel;
         wd = local_wdata;
      end else if (lnk.req && !st_q.ack && !st_q.rej && !local_req) begin
         wr = 1'b1; // [R15]
      end
   end
   // range checks and the write itself
   always_comb begin
      st_d = st_q;
      st_d.ack = 1'b0;
      st_d.rej = 1'b0;
      st_d.ldone = 1'b0;
      st_d.tx_pdo = 1'b0;
      st_d.hb_pulse = 1'b0;
      st_d.rx_event = 1'b0;
      ok = 1'b0;
      if (wr) begin
         case (sel)
            CNP_P_NODE_ID: begin
               ok = (wd >= 32'(CNP_NODE_MIN)) && (wd <= 32'(CNP_NODE_MAX)); // [R01]
               if (ok) begin
                  st_d.node_id = wd[6:0];
               end
            end
            CNP_P_BAUD: begin
               ok = wd < 32'h8;
               if (ok) begin
                  st_d.baud = wd[2:0]; // [R04]
               end
            end
            CNP_P_SYNC_EN: begin
               ok = wd < 32'h2;
               if (ok) begin
                  st_d.sync_en = wd[0];
               end
            end
            CNP_P_CYCLE: begin
               ok = 1'b1; // [R06] full 32-bit range
               st_d.cycle = wd;
            end
            CNP_P_HEARTBEAT: begin
               ok = wd <= 32'(CNP_HB_MAX); // [R07]
               if (ok) begin
                  st_d.hb = wd[15:0];
               end
            end
            CNP_P_AUTOSTART: begin
               ok = (wd < 32'h2) && !(wd[0] && st_q.srdo_use); // [R09]
               if (ok) begin
                  st_d.autostart = wd[0];
               end
            end
            CNP_P_SRDO_USE: begin
               ok = wd < 32'h2;
               if (ok) begin
                  st_d.srdo_use = wd[0];
                  if (wd[0]) begin
                     st_d.autostart = 1'b0; // [R09]
                  end
               end
            end
            CNP_P_RX_EN: begin
               ok = wd < 32'h2;
               if (ok) begin
                  st_d.rx_en = wd[0];
               end
            end
            CNP_P_RX_COBID: begin
               ok = st_q.rx_en && (wd >= 32'(CNP_RX_COB_MIN))
                  && (wd <= 32'(CNP_RX_COB_MAX)); // [R10] [R14]
               if (ok) begin
                  st_d.rx_cob = wd[10:0];
               end
            end
            CNP_P_RX_TTYPE: begin
               ok = st_q.rx_en && ((wd <= 32'(CNP_TT_SYNC_MAX))
                  || (wd == 32'(CNP_TT_EVENT))); // [R11] [R14]
               if (ok) begin
                  st_d.ttype = wd[7:0];
               end
            end
            CNP_P_RX_INHIBIT: begin
               ok = st_q.rx_en && (wd < 32'h10000); // [R12] [R14]
               if (ok) begin
                  st_d.inhibit = wd[15:0];
               end
            end
            CNP_P_RX_EVTIMER: begin
               ok = st_q.rx_en && (wd < 32'h10000); // [R13] [R14]
               if (ok) begin
                  st_d.evtimer = wd[15:0];
                  st_d.ev_cnt = '0;
               end
            end
            CNP_P_SAFETY_UP: begin
               ok = wd < 32'h2;
               if (ok) begin
                  st_d.safety_up = wd[0];
               end
            end
            CNP_P_SRC_SEL: begin
               ok = wd < 32'h2;
               if (ok) begin
                  st_d.src_srdo = wd[0];
               end
            end
            default: ok = 1'b0; // [R17]
         endcase
         // failed check leaves stored value untouched [R17]
         if (local_req) begin
            st_d.ldone = 1'b1;
         end else begin
            st_d.ack = ok;
            st_d.rej = !ok;
         end
      end
      // cob-ids follow the node id [R03]
      st_d.tx_cob = CNP_TX_COB_BASE + 11'(st_d.node_id);
      if (wr && sel == CNP_P_NODE_ID && ok) begin
         st_d.rx_cob = CNP_RX_COB_BASE + 11'(wd[6:0]); // [R03]
      end
      // autostart into operational [R08]
      if (st_q.autostart && st_q.safety_up && !st_q.srdo_use) begin
         st_d.operational = 1'b1;
      end else if (!st_q.safety_up) begin
         st_d.operational = 1'b0;
      end
      // sync: send pdo once cyc_cnt (us above bit 4, clocks below) reaches the raw cycle value [R05]
      if (st_q.sync_en && lnk.sync_msg) begin
         st_d.tx_pend = 1'b1;
         st_d.cyc_cnt = '0;
      end else if (st_q.tx_pend) begin
         if (st_q.cyc_cnt >= st_q.cycle) begin
            st_d.tx_pend = 1'b0;
            st_d.tx_pdo = 1'b1; // [R05]
         end else if (st_q.cyc_cnt[3:0] == 4'(CNP_CLK_PER_US - 1)) begin
            st_d.cyc_cnt = st_q.cyc_cnt + 32'h10 - 32'h9; // one us step
         end else begin
            st_d.cyc_cnt = st_q.cyc_cnt + 32'h1;
         end
      end
      // heartbeat producer, period in ms
      if (st_q.hb == '0) begin
         st_d.hb_cnt = '0;
      end else if (st_q.hb_cnt >= 32'(st_q.hb) * 32'(CNP_CLK_PER_MS) - 32'h1) begin
         st_d.hb_cnt = '0;
         st_d.hb_pulse = 1'b1; // [R07]
      end else begin
         st_d.hb_cnt = st_q.hb_cnt + 32'h1;
      end
      // event timer raises receive event, ms units [R13]
      if (!st_q.rx_en || st_q.evtimer == '0) begin
         st_d.ev_cnt = '0;
      end else if (st_q.ev_cnt >=
            32'(st_q.evtimer) * 32'(CNP_CLK_PER_MS) - 32'h1) begin
         st_d.ev_cnt = '0;
         st_d.rx_event = 1'b1; // [R13]
      end else if (!(wr && sel == CNP_P_RX_EVTIMER)) begin
         st_d.ev_cnt = st_q.ev_cnt + 32'h1;
      end
      // case inputs taken from selected enabled source [R16]
      if (st_q.src_srdo ? st_q.srdo_use : st_q.rx_en) begin
         st_d.case_q = lnk.case_in;
      end else begin
         st_d.case_q = '0;
      end
   end
   // state register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.node_id <= CNP_NODE_RST;
         st_q.baud <= CNP_BAUD_RST;
         st_q.ttype <= CNP_TT_RST;
         st_q.rx_cob <= CNP_RX_COB_BASE + 11'(CNP_NODE_RST);
         st_q.tx_cob <= CNP_TX_COB_BASE + 11'(CNP_NODE_RST);
      end else begin
         st_q <= st_d;
      end
   end
   assign lnk.ack = st_q.ack;
   assign lnk.rej = st_q.rej;
   assign lnk.tx_pdo = st_q.tx_pdo;
   assign lnk.rx_event = st_q.rx_event;
   assign lnk.operational = st_q.operational;
   assign lnk.tx_cob = st_q.tx_cob;
   assign local_done = st_q.ldone;
   assign case_sel = st_q.case_q;
   assign baud_sel = st_q.baud;
   assign heartbeat = st_q.hb_pulse;
endmodule

//--- src/cnp_master.sv
// cnp_master: apb-driven controller end writing node parameters
// assumes: apb slave with zero wait states; node answers ack or rej
module cnp_master
   import cnp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   cnp_if.master lnk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sync_in
);
   import cnp_pkg::*;
   typedef struct packed {
      logic busy;
      logic [3:0] sel;
      logic [31:0] wdata;
      logic ack;
      logic rej;
      logic evt;
      logic [7:0] case_in;
      logic [31:0] rdata;
      logic err;
   } cnp_mst_s;
   cnp_mst_s st_q, st_d;
   logic acc;
   // apb decode, request held to the node until answered [R15]
   always_comb begin
      st_d = st_q;
      st_d.err = 1'b0;
      acc = psel && penable;
      if (st_q.busy && (lnk.ack || lnk.rej)) begin
         st_d.busy = 1'b0;
         st_d.ack = lnk.ack;
         st_d.rej = lnk.rej; // [R17]
      end
      if (lnk.rx_event) begin
         st_d.evt = 1'b1; // set wins over clear
      end
      if (psel && !penable) begin
         if (paddr == CNP_A_STATUS) begin
            st_d.rdata = {27'h0, lnk.operational, st_q.evt, st_q.rej,
               st_q.ack, st_q.busy};
         end else if (paddr == CNP_A_TXCOB) begin
            st_d.rdata = {21'h0, lnk.tx_cob};
         end else if (paddr == CNP_A_WDATA) begin
            st_d.rdata = st_q.wdata;
         end else if (paddr == CNP_A_INPUTS) begin
            st_d.rdata = {24'h0, st_q.case_in};
         end else begin
            st_d.rdata = {28'h0, st_q.sel};
         end
      end
      // mapped reads never flag; cmd while busy and holes do
      if (acc) begin
         if (paddr == CNP_A_CMD) begin
            if (pwrite && st_q.busy) begin
               st_d.err = 1'b1;
            end else if (pwrite) begin
               st_d.sel = pwdata[3:0];
               st_d.busy = pwdata[8];
               if (pwdata[8]) begin
                  st_d.ack = 1'b0;
                  st_d.rej = 1'b0;
               end
            end
         end else if (paddr == CNP_A_WDATA) begin
            if (pwrite) begin
               st_d.wdata = pwdata;
            end
         end else if (paddr == CNP_A_INPUTS) begin
            if (pwrite) begin
               st_d.case_in = pwdata[7:0]; // [R16] unused cases zero
            end
         end else if (paddr == CNP_A_STATUS) begin
            if (pwrite && pwdata[3] && !lnk.rx_event) begin
               st_d.evt = 1'b0;
            end
         end else if (paddr != CNP_A_TXCOB) begin
            st_d.err = 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign lnk.req = st_q.busy;
   assign lnk.sel = st_q.sel;
   assign lnk.wdata = st_q.wdata;
   assign lnk.sync_msg = sync_in;
   assign lnk.case_in = st_q.case_in;
   assign pready = 1'b1;
   assign pslverr = psel && penable && st_d.err;
   assign prdata = st_q.rdata;
endmodule

//--- sim/cnp_chk_asserts.sv
// cnp_chk: link checks between master end and node end
// assumes: cnp_if signals on core_clk, rst_n active low
module cnp_chk
   import cnp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic req,
   input wire logic [3:0] sel,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire logic rej,
   input wire logic tx_pdo,
   input wire logic [10:0] tx_cob
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic take;
   // a fresh request waiting for its answer
   assign take = req && !ack && !rej;
   // tpdo cob-id tracks the accepted node id
   a_cob_follow: assert property (ack && sel == CNP_P_NODE_ID
      |-> tx_cob == CNP_TX_COB_BASE + {4'h0, wdata[6:0]})
      else $error("tpdo cob-id not rederived");
   a_answer_excl: assert property (!(ack && rej))
      else $error("ack and reject together");
   a_answer_pulse: assert property ((ack || rej) |=> !ack && !rej)
      else $error("answer longer than one cycle");
   a_answer_cause: assert property ((ack || rej) |-> $past(req))
      else $error("answer without request");
   a_req_answered: assert property ($rose(req) |-> ##[1:40] (ack || rej))
      else $error("request not answered");
   a_node_range: assert property (take && sel == CNP_P_NODE_ID
      && (wdata == 32'h0 || wdata > 32'h7F) |=> !ack)
      else $error("bad node id accepted");
   a_cob_range: assert property (take && sel == CNP_P_RX_COBID
      && (wdata < 32'h201 || wdata > 32'h27F) |=> !ack)
      else $error("bad rpdo cob-id accepted");
   a_hb_range: assert property (take && sel == CNP_P_HEARTBEAT
      && wdata > 32'hFF4B |=> !ack)
      else $error("bad heartbeat accepted");
   a_ttype_range: assert property (take && sel == CNP_P_RX_TTYPE
      && wdata > 32'hF0 && wdata != 32'hFF |=> !ack)
      else $error("bad transmission type accepted");
   a_delay_range: assert property (take && wdata[31:16] != 16'h0
      && (sel == CNP_P_RX_INHIBIT || sel == CNP_P_RX_EVTIMER) |=> !ack)
      else $error("bad inhibit or event timer accepted");
   // main traffic seen
   c_ack: cover property (ack);
   c_rej: cover property (rej);
   c_tx: cover property (tx_pdo);
endmodule

//--- sim/testbench.sv
// testbench: master and node joined by cnp_if, driven over apb
// assumes: 10 MHz core_clk, zero-wait apb slave in the master
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import cnp_pkg::*;
   logic core_clk, rst_n, psel, penable, pwrite, sync_in, err;
   logic pready, pslverr, local_req, local_done, heartbeat;
   logic [7:0] paddr, case_sel;
   logic [31:0] pwdata, prdata, rd, local_wdata;
   logic [3:0] local_sel;
   logic [2:0] baud_sel;
   int miscompares, cmp_count, n;
   cnp_if lnk ();
   cnp_node i_cnp_node (.core_clk, .rst_n, .lnk, .local_req, .local_sel,
      .local_wdata, .local_done, .case_sel, .baud_sel, .heartbeat);
   cnp_master i_cnp_master (.core_clk, .rst_n, .lnk, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sync_in);
   cnp_chk i_cnp_chk (.core_clk, .rst_n, .req(lnk.req), .sel(lnk.sel),
      .wdata(lnk.wdata), .ack(lnk.ack), .rej(lnk.rej),
      .tx_pdo(lnk.tx_pdo), .tx_cob(lnk.tx_cob));
   // 100 ns clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // one apb transfer, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   // network write of one parameter, judged by status ack/reject
   task automatic put(input cnp_param_e s, input logic [31:0] v,
      input logic ok);
      apb(1'b1, CNP_A_WDATA, v);
      apb(1'b1, CNP_A_CMD, 32'h100 | 32'(s));
      apb(1'b0, CNP_A_STATUS, '0);
      while (rd[0] !== 1'b0) apb(1'b0, CNP_A_STATUS, '0);
      check(32'(rd[2:1]), {30'h0, !ok, ok});
   endtask
   // reset cob-id and unmapped address
   task automatic t_reset();
      apb(1'b0, CNP_A_TXCOB, '0);
      check(rd, 32'h181);
      apb(1'b0, 8'h14, '0);
      check(32'(err), 32'h1);
      apb(1'b0, CNP_A_STATUS, '0);
      check(32'(err), 32'h0);
   endtask
   // node id bounds and derived cob-id
   task automatic t_node();
      put(CNP_P_NODE_ID, 32'h0, 1'b0);
      put(CNP_P_NODE_ID, 32'h80, 1'b0);
      apb(1'b0, CNP_A_TXCOB, '0);
      check(rd, 32'h181);
      put(CNP_P_NODE_ID, 32'h7F, 1'b1);
      apb(1'b0, CNP_A_TXCOB, '0);
      check(rd, 32'h1FF);
      put(CNP_P_NODE_ID, 32'h3F, 1'b1);
      apb(1'b0, CNP_A_TXCOB, '0);
      check(rd, 32'h1BF);
   endtask
   // rpdo enable gate and field bounds
   task automatic t_rpdo();
      put(CNP_P_RX_EN, 32'h0, 1'b1);
      put(CNP_P_RX_COBID, 32'h210, 1'b0);
      put(CNP_P_RX_EN, 32'h1, 1'b1);
      put(CNP_P_RX_COBID, 32'h200, 1'b0);
      put(CNP_P_RX_COBID, 32'h280, 1'b0);
      put(CNP_P_RX_COBID, 32'h27F, 1'b1);
      put(CNP_P_RX_TTYPE, 32'hF0, 1'b1);
      put(CNP_P_RX_TTYPE, 32'hF1, 1'b0);
      put(CNP_P_RX_TTYPE, 32'hFF, 1'b1);
      put(CNP_P_RX_INHIBIT, 32'hFFFF, 1'b1);
      put(CNP_P_RX_INHIBIT, 32'h10000, 1'b0);
      put(CNP_P_RX_EVTIMER, 32'h10000, 1'b0);
   endtask
   // heartbeat, cycle and baud settings
   task automatic t_net();
      put(CNP_P_HEARTBEAT, 32'hFF4B, 1'b1);
      put(CNP_P_HEARTBEAT, 32'hFF4C, 1'b0);
      put(CNP_P_HEARTBEAT, 32'h0, 1'b1);
      put(CNP_P_CYCLE, 32'hFFFFFFFF, 1'b1);
      put(CNP_P_BAUD, 32'h3, 1'b1);
      check(32'(baud_sel), 32'h3);
   endtask
   // 1 ms heartbeat period measured between two beats
   task automatic t_hb();
      put(CNP_P_HEARTBEAT, 32'h1, 1'b1);
      n = 0;
      while (heartbeat !== 1'b1 && n < 11000) begin
         @(posedge core_clk);
         n++;
      end
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (heartbeat !== 1'b1 && n < 11000);
      check(32'(n), 32'(CNP_CLK_PER_MS));
      put(CNP_P_HEARTBEAT, 32'h0, 1'b1);
   endtask
   // sync ignored while off, then answered by tpdo within 2 us
   task automatic t_sync();
      sync_in <= 1'b1;
      @(posedge core_clk);
      sync_in <= 1'b0;
      n = 0;
      repeat (30) begin
         @(posedge core_clk);
         n += int'(lnk.tx_pdo === 1'b1);
      end
      check(32'(n), 32'h0);
      put(CNP_P_SYNC_EN, 32'h1, 1'b1);
      put(CNP_P_CYCLE, 32'h2, 1'b1);
      sync_in <= 1'b1;
      @(posedge core_clk);
      sync_in <= 1'b0;
      n = 0;
      while (lnk.tx_pdo !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         n++;
      end
      check(32'(n <= 2 * CNP_CLK_PER_US + 1), 32'h1);
   endtask
   // autostart refused with srdos, then operational on safety start
   task automatic t_auto();
      put(CNP_P_SRDO_USE, 32'h1, 1'b1);
      put(CNP_P_AUTOSTART, 32'h1, 1'b0);
      put(CNP_P_SRDO_USE, 32'h0, 1'b1);
      put(CNP_P_AUTOSTART, 32'h1, 1'b1);
      put(CNP_P_SAFETY_UP, 32'h1, 1'b1);
      apb(1'b0, CNP_A_STATUS, '0);
      check(32'(rd[4]), 32'h1);
   endtask
   // 1 ms event timer raises and clears receive event
   task automatic t_evt();
      put(CNP_P_RX_EVTIMER, 32'h1, 1'b1);
      n = 0;
      while (lnk.rx_event !== 1'b1 && n < 12000) begin
         @(posedge core_clk);
         n++;
      end
      check(32'(n < 12000), 32'h1);
      put(CNP_P_RX_EVTIMER, 32'h0, 1'b1);
      apb(1'b0, CNP_A_STATUS, '0);
      check(32'(rd[3]), 32'h1);
      apb(1'b1, CNP_A_STATUS, 32'h8);
      apb(1'b0, CNP_A_STATUS, '0);
      check(32'(rd[3]), 32'h0);
   endtask
   // local tool write of node id 5
   task automatic t_local();
      local_sel <= CNP_P_NODE_ID;
      local_wdata <= 32'h5;
      local_req <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (local_done !== 1'b1 && n < 20);
      local_req <= 1'b0;
      check(32'(n < 20), 32'h1);
      apb(1'b0, CNP_A_TXCOB, '0);
      check(rd, 32'h185);
   endtask
   // case inputs pass only from the selected source, rpdo or srdo, when enabled
   task automatic t_case();
      apb(1'b1, CNP_A_INPUTS, 32'hA5);
      put(CNP_P_SRC_SEL, 32'h0, 1'b1);
      check(32'(case_sel), 32'hA5);
      put(CNP_P_RX_EN, 32'h0, 1'b1);
      check(32'(case_sel), 32'h0);
      put(CNP_P_SRC_SEL, 32'h1, 1'b1);
      check(32'(case_sel), 32'h0);
      put(CNP_P_SRDO_USE, 32'h1, 1'b1);
      check(32'(case_sel), 32'hA5);
   endtask
   // main sequence
   initial begin
      {psel, penable, pwrite, sync_in, local_req} = '0;
      paddr = '0;
      pwdata = '0;
      local_sel = '0;
      local_wdata = '0;
      miscompares = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_node();
      t_rpdo();
      t_net();
      t_hb();
      t_sync();
      t_auto();
      t_evt();
      t_local();
      t_case();
      report_and_stop();
   end
   // watchdog
   initial begin
      #8000000;
      miscompares++;
      report_and_stop();
   end
endmodule
